// ---- core/aisp_regs.vh ----
// constants for the two-wire slave port of the converter
`ifndef AISP_REGS_VH
`define AISP_REGS_VH
// address base and general call
`define AISP_ADDR_BASE 5'h12
`define AISP_GCALL_ADDR 7'h00
`define AISP_GCALL_RESET 8'h06
// high-speed master code top five bits 00001
`define AISP_HS_CODE_TOP 5'h01
// pointer selects
`define AISP_PTR_CONV 2'h0
`define AISP_PTR_CFG 2'h1
`define AISP_PTR_LO 2'h2
`define AISP_PTR_HI 2'h3
// register reset values
`define AISP_CFG_RST 16'h8583
`define AISP_LO_RST 16'h8000
`define AISP_HI_RST 16'h7FF0
`define AISP_CONV_RST 16'h0000
// config power-down bit
`define AISP_CFG_MODE_BIT 8
// idle timeout: time in us and clock rate in MHz
`define AISP_TIMEOUT_US 25000
`define AISP_CLK_MHZ 20
`define AISP_TIMEOUT_CYC (`AISP_TIMEOUT_US * `AISP_CLK_MHZ)
`endif

// ---- core/aisp_slave.v ----
// two-wire slave port with pointer and four 16-bit registers
`timescale 1ns/1ps
`include "aisp_regs.vh"

module aisp_slave (
  input wire i_clk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  input wire [1:0] i_addr_sel,
  input wire [15:0] i_conv_data,
  output reg o_sda_out,
  output reg o_sda_oe,
  output reg o_hs_mode,
  output reg [15:0] o_cfg,
  output reg [15:0] o_lo_thresh,
  output reg [15:0] o_hi_thresh,
  output reg o_gcall_rst
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam [5:0] ST_IDLE = 6'h01;
localparam [5:0] ST_ADDR = 6'h02;
localparam [5:0] ST_WR = 6'h04;
localparam [5:0] ST_RD = 6'h08;
localparam [5:0] ST_GC = 6'h10;
localparam [5:0] ST_IGN = 6'h20;

// ----------------------------------------------------------------
// pin synchronisers and edge finding
// ----------------------------------------------------------------
reg [1:0] scl_s_r;
reg [1:0] sda_s_r;
reg [1:0] sel_a_r;
reg [1:0] sel_b_r;
reg scl_d_r;
reg sda_d_r;
wire scl_rise;
wire scl_fall;
wire start_det;
wire stop_det;

// two flops per pin; only the second stage feeds logic
// reset values match the idle-high bus, so no false edge follows reset
always @(posedge i_clk) begin
  if (i_rst) begin
    scl_s_r <= 2'h3;
    sda_s_r <= 2'h3;
    sel_a_r <= 2'h0;
    sel_b_r <= 2'h0;
    scl_d_r <= 1'b1;
    sda_d_r <= 1'b1;
  end else begin
    scl_s_r <= {scl_s_r[0], i_scl};
    sda_s_r <= {sda_s_r[0], i_sda};
    sel_a_r <= i_addr_sel;
    sel_b_r <= sel_a_r;
    scl_d_r <= scl_s_r[1];
    sda_d_r <= sda_s_r[1];
  end
end

// no speed activation
// clock edges are found by oversampling, so standard and fast rates
// need no mode switch; the bus clock must stay low and high for at
// least three system clocks, which high-speed rates do not give
assign scl_rise = scl_s_r[1] & ~scl_d_r;
assign scl_fall = ~scl_s_r[1] & scl_d_r;
assign start_det = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
assign stop_det = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];

// ----------------------------------------------------------------
// byte engine
// ----------------------------------------------------------------
reg [5:0] state_r;
reg [3:0] bit_cnt_r;
reg [7:0] shift_r;
reg [1:0] ptr_r;
reg [1:0] wr_idx_r;
reg [7:0] msb_hold_r;
reg rd_lsb_r;
reg ack_phase_r;
reg [15:0] conv_r;
reg [23:0] idle_cnt_r;
wire to_hit;
wire [6:0] own_addr;
wire [7:0] rx_byte;
reg [15:0] rd_word;

// address follows the select pin continuously
assign own_addr = {`AISP_ADDR_BASE, sel_b_r};
assign rx_byte = {shift_r[6:0], sda_s_r[1]};

// idle limit reached
// compared at the full width of the constant; 25 ms at 20 MHz is
// 500000 cycles, which still fits the 24-bit counter with room to spare
assign to_hit = ({8'h00, idle_cnt_r} == `AISP_TIMEOUT_CYC);

// pointer selects the word read back
always @* begin
  case (ptr_r)
    `AISP_PTR_CONV: rd_word = conv_r;
    `AISP_PTR_CFG: rd_word = o_cfg;
    `AISP_PTR_LO: rd_word = o_lo_thresh;
    default: rd_word = o_hi_thresh;
  endcase
end

// main sequencer; ack and data bits change only on clock falls
// acting on the synchronised fall keeps every data change inside the
// low phase, well clear of the next rise the master sees
always @(posedge i_clk) begin
  if (i_rst) begin
    state_r <= ST_IDLE;
    bit_cnt_r <= 4'h0;
    shift_r <= 8'h00;
    ptr_r <= 2'h0;
    wr_idx_r <= 2'h0;
    msb_hold_r <= 8'h00;
    rd_lsb_r <= 1'b0;
    ack_phase_r <= 1'b0;
    conv_r <= `AISP_CONV_RST;
    idle_cnt_r <= 24'h000000;
    o_sda_out <= 1'b0;
    o_sda_oe <= 1'b0;
    o_hs_mode <= 1'b0;
    o_cfg <= `AISP_CFG_RST;
    o_lo_thresh <= `AISP_LO_RST;
    o_hi_thresh <= `AISP_HI_RST;
    o_gcall_rst <= 1'b0;
  end else begin
    // the reset pulse lasts one cycle; a repeated command gives a new pulse
    o_gcall_rst <= 1'b0;
    // conversion word is re-sampled each cycle; a read may see two
    // different words if the core updates between msb and lsb
    conv_r <= i_conv_data;
    // idle timeout counter, cleared in idle and by any clock-line edge
    if (state_r == ST_IDLE || scl_rise || scl_fall)
      idle_cnt_r <= 24'h000000;
    else
      idle_cnt_r <= idle_cnt_r + 24'h000001;
    if (start_det) begin
      // start or repeated start opens address phase
      state_r <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      ack_phase_r <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (stop_det) begin
      // stop leaves high speed; release data
      // a stop always returns to idle, whatever the state
      state_r <= ST_IDLE;
      o_sda_oe <= 1'b0;
      o_hs_mode <= 1'b0;
    end else if (to_hit) begin
      // abandon transfer
      // high-speed flag is left alone: only a stop ends it
      state_r <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end else if (state_r != ST_IDLE && state_r != ST_IGN) begin
      if (scl_rise && !ack_phase_r && state_r != ST_RD) begin
        shift_r <= rx_byte;
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (scl_rise && ack_phase_r && state_r == ST_RD) begin
        if (sda_s_r[1])
          state_r <= ST_IGN;
      end
      if (scl_rise && !ack_phase_r && state_r == ST_RD)
        bit_cnt_r <= bit_cnt_r + 4'h1;
      if (scl_fall) begin
        if (ack_phase_r) begin
          // end of ninth clock: release, then start next byte
          ack_phase_r <= 1'b0;
          bit_cnt_r <= 4'h0;
          o_sda_oe <= 1'b0;
          if (state_r == ST_RD) begin
            // msb then lsb
            // rd_lsb_r marks that the msb has gone, so the lsb is next;
            // after an acked lsb the same word starts again at its msb
            rd_lsb_r <= ~rd_lsb_r;
            o_sda_oe <= 1'b1;
            o_sda_out <= rd_lsb_r ? rd_word[7] : rd_word[15];
            shift_r <= rd_lsb_r ? {rd_word[6:0], 1'b1} :
              {rd_word[14:8], 1'b1};
          end
        end else if (bit_cnt_r == 4'h8) begin
          ack_phase_r <= 1'b1;
          o_sda_out <= 1'b0;
          o_sda_oe <= 1'b0;
          case (state_r)
            ST_ADDR: begin
              if (shift_r[7:1] == own_addr) begin
                o_sda_oe <= 1'b1;
                state_r <= shift_r[0] ? ST_RD : ST_WR;
                wr_idx_r <= 2'h0;
                rd_lsb_r <= 1'b0;
              end else if (shift_r[7:1] == `AISP_GCALL_ADDR &&
                  !shift_r[0]) begin
                o_sda_oe <= 1'b1;
                state_r <= ST_GC;
              end else if (shift_r[7:3] == `AISP_HS_CODE_TOP) begin
                // master code: no ack, high speed on
                o_hs_mode <= 1'b1;
                state_r <= ST_IGN;
              end else begin
                state_r <= ST_IGN;
              end
            end
            ST_WR: begin
              o_sda_oe <= 1'b1;
              if (wr_idx_r == 2'h0) begin
                // pointer byte kept
                // only the select bits are kept; bits 7 to 2 should be zero
                ptr_r <= shift_r[1:0];
                wr_idx_r <= 2'h1;
              end else if (wr_idx_r == 2'h1) begin
                msb_hold_r <= shift_r;
                wr_idx_r <= 2'h2;
              end else begin
                wr_idx_r <= 2'h1;
                // conversion word is read-only: its bytes are acked, dropped
                case (ptr_r)
                  `AISP_PTR_CFG: o_cfg <= {msb_hold_r, shift_r};
                  `AISP_PTR_LO: o_lo_thresh <= {msb_hold_r, shift_r};
                  `AISP_PTR_HI: o_hi_thresh <= {msb_hold_r, shift_r};
                  default: o_cfg <= o_cfg;
                endcase
              end
            end
            ST_GC: begin
              o_sda_oe <= 1'b1;
              if (shift_r == `AISP_GCALL_RESET) begin
                o_cfg <= `AISP_CFG_RST;
                o_lo_thresh <= `AISP_LO_RST;
                o_hi_thresh <= `AISP_HI_RST;
                ptr_r <= 2'h0;
                o_gcall_rst <= 1'b1;
              end
            end
            default: begin
              // read: release for master ack
              o_sda_oe <= 1'b0;
            end
          endcase
        end else if (state_r == ST_RD) begin
          o_sda_oe <= 1'b1;
          o_sda_out <= shift_r[7];
          shift_r <= {shift_r[6:0], 1'b1};
        end
      end
      // address ack falling edge starts read msb; wr_idx_r is parked at
      // 3 during reads so this load happens once per address phase
      if (scl_fall && ack_phase_r && state_r == ST_RD &&
          !rd_lsb_r && wr_idx_r == 2'h0) begin
        wr_idx_r <= 2'h3;
        rd_lsb_r <= 1'b1;
        o_sda_oe <= 1'b1;
        o_sda_out <= rd_word[15];
        shift_r <= {rd_word[14:8], 1'b1};
      end
    end
  end
end

endmodule

// ---- testbench/aisp_master_model.sv ----
// two-wire bus master model: drives the clock and pulls data low
`timescale 1ns/1ps
module aisp_master_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl = 1'b1,
  output logic o_sda_low = 1'b0
);
  int half = 4; // half link period in clocks: 400 ns per bit
  task automatic gap(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // one line moves per step, so no false start or stop appears
  task automatic drv(input logic c, input logic l);
    gap(half);
    o_scl <= c;
    o_sda_low <= l;
  endtask
  // data set while clock low, sampled at end of high
  task automatic xbit(input bit b, output bit r);
    gap(half / 2);
    o_sda_low <= !b;
    gap(half - half / 2);
    o_scl <= 1'b1;
    gap(half);
    r = i_sda;
    o_scl <= 1'b0;
  endtask
  // start works from idle and as repeated start
  task automatic start;
    drv(o_scl, 1'b0);
    drv(1'b1, 1'b0);
    drv(1'b1, 1'b1);
    drv(1'b0, 1'b1);
  endtask
  task automatic stop;
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
  endtask
  task automatic wbyte(input logic [7:0] d, output bit nak);
    bit r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, nak);
  endtask
  // master clocks the ack bit and acks or not
  task automatic rbyte(input bit nak, output logic [7:0] d);
    bit r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(nak, r);
  endtask
endmodule

// ---- testbench/aisp_slave_monitor.sv ----
// pin-level checks on the two-wire slave port
`timescale 1ns/1ps
`include "aisp_regs.vh"
module aisp_slave_monitor (
  input wire i_clk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  input wire o_sda_out,
  input wire o_sda_oe,
  input wire o_hs_mode,
  input wire [15:0] o_cfg,
  input wire [15:0] o_lo_thresh,
  input wire [15:0] o_hi_thresh,
  input wire o_gcall_rst
);
  localparam int TO_LIM = `AISP_TIMEOUT_CYC + 8;
  logic scl_d_r;
  int idle_cnt_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // idle time on the clock line; saturates to stay cheap
  always @(posedge i_clk) begin
    scl_d_r <= i_scl;
    if (i_rst || i_scl != scl_d_r) idle_cnt_r <= 0;
    else if (idle_cnt_r < TO_LIM) idle_cnt_r <= idle_cnt_r + 1;
  end
  sequence start_s;
    i_scl && $fell(i_sda);
  endsequence
  sequence stop_s;
    i_scl && $rose(i_sda);
  endsequence
  oe_edge_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data drive changed while clock high");
  data_hold_a: assert property
    (o_sda_oe && $past(o_sda_oe) && $changed(o_sda_out) |-> !i_scl)
    else $error("driven data changed while clock high");
  start_rel_a: assert property (start_s |-> ##[0:4] !o_sda_oe)
    else $error("data still driven after start");
  stop_rel_a: assert property (stop_s |-> ##[0:4] !o_sda_oe)
    else $error("data still driven after stop");
  gc_pulse_a: assert property (o_gcall_rst |=> !o_gcall_rst)
    else $error("reset pulse longer than one cycle");
  gc_dflt_a: assert property (o_gcall_rst |-> ##[0:3]
    (o_cfg == `AISP_CFG_RST && o_lo_thresh == `AISP_LO_RST
     && o_hi_thresh == `AISP_HI_RST)) else $error("defaults not restored");
  hs_exit_a: assert property
    (o_hs_mode ##0 stop_s |-> ##[1:5] !o_hs_mode)
    else $error("high speed kept after stop");
  reg_upd_a: assert property
    ($changed({o_cfg, o_lo_thresh, o_hi_thresh}) |-> !i_scl)
    else $error("register changed while clock high");
  idle_to_a: assert property (idle_cnt_r >= TO_LIM |-> !o_sda_oe)
    else $error("data driven after idle timeout");
endmodule
bind aisp_slave aisp_slave_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_hs_mode(o_hs_mode), .o_cfg(o_cfg),
  .o_lo_thresh(o_lo_thresh), .o_hi_thresh(o_hi_thresh),
  .o_gcall_rst(o_gcall_rst));

// ---- testbench/aisp_slave_test.sv ----
// self-checking bench for the two-wire slave port
`timescale 1ns/1ps
`include "aisp_regs.vh"
module aisp_slave_test;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [1:0] sel = 2'h0;
  logic [15:0] conv = 16'h0000;
  logic [15:0] rw;
  wire scl, m_low, s_out, s_oe, hs, gpulse;
  wire [15:0] cfg, lo, hi;
  wire sda_w = !(m_low || (s_oe && !s_out)); // pull-up when released
  int err_count = 0, check_count = 0, m_reg[4], m_ptr = 0;
  bit k, gseen = 0;
  aisp_master_model u_aisp_master_model (.i_clk(i_clk), .i_sda(sda_w),
    .o_scl(scl), .o_sda_low(m_low));
  aisp_slave u_aisp_slave (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl),
    .i_sda(sda_w), .i_addr_sel(sel), .i_conv_data(conv), .o_sda_out(s_out),
    .o_sda_oe(s_oe), .o_hs_mode(hs), .o_cfg(cfg), .o_lo_thresh(lo),
    .o_hi_thresh(hi), .o_gcall_rst(gpulse));
  initial forever #25 i_clk = ~i_clk;
  // the reset pulse lasts one cycle, so keep a sticky copy
  always @(posedge i_clk) if (gpulse) gseen <= 1'b1;
  task chk(input logic [15:0] s, input logic [15:0] e, input string m);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task regs;
    chk(cfg, m_reg[1], "cfg");
    chk(lo, m_reg[2], "lo");
    chk(hi, m_reg[3], "hi");
  endtask
  // write n bytes of v, pointer first; a stranger sees nack throughout
  task wr(input logic [6:0] a, input int n, input logic [23:0] v);
    bit hit;
    hit = (a == 7'h48 + sel);
    u_aisp_master_model.start();
    u_aisp_master_model.wbyte({a, 1'b0}, k);
    chk(k, !hit, "addr ack");
    for (int i = 0; i < n; i++) begin
      u_aisp_master_model.wbyte(v[23 - 8 * i -: 8], k);
      chk(k, !hit, "byte ack");
    end
    if (hit && n > 0) m_ptr = v[17:16];
    if (hit && n == 3 && m_ptr != 0) m_reg[m_ptr] = v[15:0];
  endtask
  task rd;
    u_aisp_master_model.start();
    u_aisp_master_model.wbyte({7'h48 + sel, 1'b1}, k);
    chk(k, 1'b0, "read ack");
    u_aisp_master_model.rbyte(1'b0, rw[15:8]);
    u_aisp_master_model.rbyte(1'b1, rw[7:0]);
    chk(rw, m_ptr ? m_reg[m_ptr] : conv, "read data");
    chk(s_oe, 1'b0, "released after nack");
  endtask
  initial begin
    void'($urandom(54679));
    m_reg = '{0, `AISP_CFG_RST, `AISP_LO_RST, `AISP_HI_RST};
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    regs();
    for (int s = 0; s < 4; s++) begin
      sel <= s[1:0];
      conv <= 16'($urandom);
      u_aisp_master_model.gap(1);
      for (int p = 1; p < 4; p++) begin
        // each strap code, every writable register
        wr(7'h48 + sel, 3, {p[7:0], 16'($urandom)});
        u_aisp_master_model.stop();
        regs();
        // pointer-only write, then read after repeated start
        wr(7'h48 + sel, 1, {p[7:0], 16'h0000});
        rd();
        rd();
        u_aisp_master_model.stop();
      end
      wr(7'h4C, 3, {8'h01, 16'h1234});
      wr(7'h48 + sel, 1, 24'h000000);
      u_aisp_master_model.stop();
      rd();
      u_aisp_master_model.stop();
      regs();
      $display("test strap %0d done", s);
    end
    u_aisp_master_model.start();
    u_aisp_master_model.wbyte(8'h0B, k);
    chk(k, 1'b1, "master code nack");
    chk(hs, 1'b1, "hs set");
    wr(7'h48 + sel, 1, 24'h010000);
    u_aisp_master_model.stop();
    u_aisp_master_model.gap(4);
    chk(hs, 1'b0, "hs cleared");
    $display("test high speed done");
    u_aisp_master_model.start();
    u_aisp_master_model.wbyte(8'h00, k);
    chk(k, 1'b0, "general call ack");
    u_aisp_master_model.wbyte(`AISP_GCALL_RESET, k);
    chk(k, 1'b0, "command ack");
    u_aisp_master_model.stop();
    u_aisp_master_model.gap(4);
    chk(gseen, 1'b1, "reset pulse");
    m_reg = '{0, `AISP_CFG_RST, `AISP_LO_RST, `AISP_HI_RST};
    m_ptr = 0;
    regs();
    rd();
    u_aisp_master_model.stop();
    $display("test general call done");
    end_sim();
  end
  // all tests take under 20000 cycles
  initial begin
    repeat (40000) @(posedge i_clk);
    err_count++;
    end_sim();
  end
endmodule
